/* File: src/hpcb_config_bank.sv */
// Hub port config bank: AXI4-Lite registers, strap sampling, port numbering and over-current filters
`default_nettype none
module hpcb_config_bank
  import hpcb_pkg::*;
#(
  parameter int PORTS = 3
) (
  input  wire logic              clock,
  input  wire logic              reset,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins
  input  wire logic              internalDefaultStrap,
  input  wire logic [1:0]        fixed_attach_straps,
  input  wire logic [1:0]        portDisableStraps,
  input  wire logic [PORTS-1:0]  overcurrentSense,
  // Hub-side outputs
  output logic                   hubCompound,
  output logic [PORTS-1:0]       fixedAttachPorts,
  output logic [PORTS-1:0]       portEnabled,
  output logic [2*PORTS-1:0]     logicalPortNum,
  output logic [1:0]             reportedPortCount,
  output logic [1:0]             overcurrent_delay_sel,
  output logic                   explicit_port_remap_sel,
  output logic                   power_source_sel,
  output logic [PORTS-1:0]       overcurrentTripped
);

  localparam int PIN_W = PORTS + 5;

  // Software-visible registers
  logic [7:0] powerConfig_reg;
  logic [7:0] configByteTwo_reg;
  logic [7:0] configByteThree_reg;
  logic [7:0] fixedPortFlags_reg;
  logic [7:0] portOffSelf_reg;
  logic [7:0] portOffBus_reg;
  logic [7:0] portRemapOneTwo_reg;
  logic [7:0] portRemapThree_reg;

  // AXI handshake state
  logic              awHeld_reg;
  logic              wHeld_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic [IDX_W-1:0]  wrIdx_reg;
  logic              wrAligned_reg;
  logic [7:0]        wrData_reg;
  logic              wrLane_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // Pin synchronisers: three stages, accepted once stages two and three agree
  logic [PIN_W-1:0] pinSync1_reg;
  logic [PIN_W-1:0] pinSync2_reg;
  logic [PIN_W-1:0] pinSync3_reg;
  logic [PIN_W-1:0] pinStable_reg;
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinAgree;

  assign pinRaw = {internalDefaultStrap, portDisableStraps, fixed_attach_straps, overcurrentSense};
  assign pinAgree = ~(pinSync2_reg ^ pinSync3_reg);

  always_ff @(posedge clock) begin
    if (reset) begin
      pinSync1_reg <= '0;
      pinSync2_reg <= '0;
      pinSync3_reg <= '0;
      pinStable_reg <= '0;
    end else begin
      pinSync1_reg <= pinRaw;
      pinSync2_reg <= pinSync1_reg;
      pinSync3_reg <= pinSync2_reg;
      pinStable_reg <= (pinSync2_reg & pinAgree) | (pinStable_reg & ~pinAgree);
    end
  end

  logic [PORTS-1:0] senseStable;
  logic [1:0]       fixedStrapStable;
  logic [1:0]       disableStrapStable;
  logic             useStraps;

  assign senseStable = pinStable_reg[PORTS-1:0];
  assign fixedStrapStable = pinStable_reg[PORTS+1:PORTS];
  assign disableStrapStable = pinStable_reg[PORTS+3:PORTS+2];
  assign useStraps = pinStable_reg[PORTS+4];

  // Write channel: either order, one write in flight; registered ready reopens as bvalid goes
  logic doWrite;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      wrIdx_reg <= '0;
      wrAligned_reg <= 1'b0;
      wrData_reg <= 8'h00;
      wrLane_reg <= 1'b0;
    end else begin
      awready_reg <= !awHeld_reg && !(s_axi_awvalid && awready_reg) && (!bvalid_reg || s_axi_bready);
      wready_reg <= !wHeld_reg && !(s_axi_wvalid && wready_reg) && (!bvalid_reg || s_axi_bready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        wrIdx_reg <= s_axi_awaddr[ADDR_W-1:2];
        wrAligned_reg <= (s_axi_awaddr[1:0] == 2'h0);
      end else if (doWrite) begin
        awHeld_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wrData_reg <= s_axi_wdata[7:0];
        wrLane_reg <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  // Decode of a stored write address; a misaligned address is unmapped
  logic wrMapped;
  always_comb begin
    case (wrIdx_reg)
      IDX_POWER_CONFIG, IDX_CONFIG_BYTE_TWO, IDX_CONFIG_BYTE_THREE, IDX_FIXED_PORT_FLAGS,
      IDX_HUB_STATUS, IDX_PORT_NUMBERS, IDX_PORT_OFF_SELF_POWERED, IDX_PORT_OFF_BUS_POWERED,
      IDX_PORT_REMAP_ONE_TWO, IDX_PORT_REMAP_THREE: wrMapped = wrAligned_reg;
      default: wrMapped = 1'b0;
    endcase
  end

  // Write response; status registers accept and ignore writes
  always_ff @(posedge clock) begin
    if (reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data, reserved bits masked off
  logic wrEn;
  assign wrEn = doWrite && wrAligned_reg && wrLane_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      powerConfig_reg <= RST_POWER_CONFIG;
      configByteTwo_reg <= RST_CONFIG_BYTE;
      configByteThree_reg <= RST_CONFIG_BYTE;
      fixedPortFlags_reg <= RST_PORT_FLAGS;
      portOffSelf_reg <= RST_PORT_OFF;
      portOffBus_reg <= RST_PORT_OFF;
      portRemapOneTwo_reg <= RST_PORT_REMAP;
      portRemapThree_reg <= RST_PORT_REMAP;
    end else if (wrEn) begin
      case (wrIdx_reg)
        IDX_POWER_CONFIG: powerConfig_reg <= wrData_reg & MASK_POWER_CONFIG;
        IDX_CONFIG_BYTE_TWO: configByteTwo_reg <= wrData_reg & MASK_CONFIG_BYTE_TWO;
        IDX_CONFIG_BYTE_THREE: configByteThree_reg <= wrData_reg & MASK_CONFIG_BYTE_THREE;
        IDX_FIXED_PORT_FLAGS: fixedPortFlags_reg <= wrData_reg & MASK_PORT_FLAGS;
        IDX_PORT_OFF_SELF_POWERED: portOffSelf_reg <= wrData_reg & MASK_PORT_FLAGS;
        IDX_PORT_OFF_BUS_POWERED: portOffBus_reg <= wrData_reg & MASK_PORT_FLAGS;
        IDX_PORT_REMAP_ONE_TWO: portRemapOneTwo_reg <= wrData_reg & MASK_PORT_REMAP;
        IDX_PORT_REMAP_THREE: portRemapThree_reg <= wrData_reg & MASK_PORT_REMAP;
        default: begin
        end
      endcase
    end
  end

  // Effective configuration, from straps under the internal default option
  logic [7:0] fixedMask;
  logic [7:0] offMask;
  logic       compoundNext;
  logic       remapSel;

  always_comb begin
    remapSel = configByteThree_reg[POS_REMAP_SEL];
    if (useStraps) begin
      fixedMask = hpcbStrapMask(fixedStrapStable);
      offMask = hpcbStrapMask(disableStrapStable);
      compoundNext = |fixedMask;
    end else begin
      fixedMask = fixedPortFlags_reg;
      offMask = powerConfig_reg[POS_POWER_SOURCE] ? portOffSelf_reg : portOffBus_reg;
      compoundNext = configByteTwo_reg[POS_COMPOUND];
    end
  end

  // Port numbering; zero means the port is not offered to the host
  logic [2*PORTS-1:0] numNext;
  logic [PORTS-1:0]   enNext;
  logic [1:0]         countNext;
  logic [1:0]         slot;
  logic [15:0]        remapAll;

  assign remapAll = {portRemapThree_reg, portRemapOneTwo_reg};

  always_comb begin
    slot = 2'h0;
    numNext = '0;
    enNext = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (remapSel) begin
        numNext[2*p +: 2] = remapAll[4*p +: 2];
      end else if (!offMask[p+1]) begin
        slot = slot + 2'h1;
        numNext[2*p +: 2] = slot;
      end
      enNext[p] = (numNext[2*p +: 2] != 2'h0);
    end
    countNext = 2'h0;
    for (int p = 0; p < PORTS; p++) begin
      countNext = countNext + {1'b0, enNext[p]};
    end
  end

  // Registered hub-side outputs; a disabled port never shows fixed-attach
  always_ff @(posedge clock) begin
    if (reset) begin
      hubCompound <= 1'b0;
      fixedAttachPorts <= '0;
      portEnabled <= '0;
      logicalPortNum <= '0;
      reportedPortCount <= 2'h0;
      overcurrent_delay_sel <= 2'h0;
      explicit_port_remap_sel <= 1'b0;
      power_source_sel <= 1'b0;
    end else begin
      hubCompound <= compoundNext;
      fixedAttachPorts <= fixedMask[PORTS:1] & enNext;
      portEnabled <= enNext;
      logicalPortNum <= numNext;
      reportedPortCount <= countNext;
      overcurrent_delay_sel <= configByteTwo_reg[POS_DELAY_LO +: 2];
      explicit_port_remap_sel <= remapSel;
      power_source_sel <= powerConfig_reg[POS_POWER_SOURCE];
    end
  end

  // Delay code to filter length; counts derive from the clock rate
  logic [3:0] delayCycles;
  always_comb begin
    case (configByteTwo_reg[POS_DELAY_LO +: 2])
      2'h0: delayCycles = OC_DELAY0_CYC;
      2'h1: delayCycles = OC_DELAY1_CYC;
      2'h2: delayCycles = OC_DELAY2_CYC;
      default: delayCycles = OC_DELAY3_CYC;
    endcase
  end

  // One filter per port; the filter adds to the synchroniser latency
  logic [PORTS-1:0] trippedNext;
  for (genvar g = 0; g < PORTS; g++) begin : gOc
    hpcb_oc_if ocLink ();
    assign ocLink.delayCycles = delayCycles;
    assign ocLink.senseIn = senseStable[g];
    assign trippedNext[g] = ocLink.tripped;
    hpcb_oc_filter uFilter (
      .clock (clock),
      .reset (reset),
      .oc    (ocLink)
    );
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      overcurrentTripped <= '0;
    end else begin
      overcurrentTripped <= trippedNext;
    end
  end

  // Read channel: one read in flight, answer registered on the same edge that takes the address
  logic [7:0]  rdByte;
  logic        rdMapped;
  logic [IDX_W-1:0] rdIdx;
  assign rdIdx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rdMapped = (s_axi_araddr[1:0] == 2'h0);
    case (rdIdx)
      IDX_POWER_CONFIG: rdByte = powerConfig_reg;
      IDX_CONFIG_BYTE_TWO: rdByte = configByteTwo_reg;
      IDX_CONFIG_BYTE_THREE: rdByte = configByteThree_reg;
      IDX_FIXED_PORT_FLAGS: rdByte = fixedPortFlags_reg;
      IDX_HUB_STATUS: rdByte = {overcurrentTripped, reportedPortCount, hubCompound, useStraps, 1'b0};
      IDX_PORT_NUMBERS: rdByte = {2'h0, logicalPortNum};
      IDX_PORT_OFF_SELF_POWERED: rdByte = portOffSelf_reg;
      IDX_PORT_OFF_BUS_POWERED: rdByte = portOffBus_reg;
      IDX_PORT_REMAP_ONE_TWO: rdByte = portRemapOneTwo_reg;
      IDX_PORT_REMAP_THREE: rdByte = portRemapThree_reg;
      default: begin
        rdByte = 8'h00;
        rdMapped = 1'b0;
      end
    endcase
    if (!rdMapped) begin
      rdByte = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rdByte};
      rresp_reg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg) begin
      if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end else begin
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

endmodule
`default_nettype wire

/* File: src/hpcb_pkg.sv */
// Package: register indices, field positions, reset values and timing for the hub port config bank
`default_nettype none
package hpcb_pkg;

  localparam int IDX_W = 14;
  localparam int ADDR_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_POWER_CONFIG = 14'h00E4;
  localparam logic [IDX_W-1:0] IDX_CONFIG_BYTE_TWO = 14'h00E5;
  localparam logic [IDX_W-1:0] IDX_CONFIG_BYTE_THREE = 14'h00E6;
  localparam logic [IDX_W-1:0] IDX_FIXED_PORT_FLAGS = 14'h00E7;
  localparam logic [IDX_W-1:0] IDX_HUB_STATUS = 14'h0100;
  localparam logic [IDX_W-1:0] IDX_PORT_NUMBERS = 14'h0101;
  localparam logic [IDX_W-1:0] IDX_PORT_OFF_SELF_POWERED = 14'h300A;
  localparam logic [IDX_W-1:0] IDX_PORT_OFF_BUS_POWERED = 14'h300B;
  localparam logic [IDX_W-1:0] IDX_PORT_REMAP_ONE_TWO = 14'h30FB;
  localparam logic [IDX_W-1:0] IDX_PORT_REMAP_THREE = 14'h30FC;

  // Writable bit masks; everything else is reserved and reads zero
  localparam logic [7:0] MASK_POWER_CONFIG = 8'h80;
  localparam logic [7:0] MASK_CONFIG_BYTE_TWO = 8'h38;
  localparam logic [7:0] MASK_CONFIG_BYTE_THREE = 8'h08;
  localparam logic [7:0] MASK_PORT_FLAGS = 8'h0E;
  localparam logic [7:0] MASK_PORT_REMAP = 8'hFF;

  // Field positions
  localparam int POS_POWER_SOURCE = 7;
  localparam int POS_DELAY_LO = 4;
  localparam int POS_COMPOUND = 3;
  localparam int POS_REMAP_SEL = 3;

  // Reset values
  localparam logic [7:0] RST_POWER_CONFIG = 8'h00;
  localparam logic [7:0] RST_CONFIG_BYTE = 8'h00;
  localparam logic [7:0] RST_PORT_FLAGS = 8'h00;
  localparam logic [7:0] RST_PORT_OFF = 8'h00;
  localparam logic [7:0] RST_PORT_REMAP = 8'h00;

  // Over-current filter delays and their cycle counts at the core clock
  localparam int CLOCK_KHZ = 20000;
  localparam int OC_DELAY0_NS = 50;
  localparam int OC_DELAY1_NS = 100;
  localparam int OC_DELAY2_NS = 200;
  localparam int OC_DELAY3_NS = 400;

  function automatic logic [3:0] hpcbNsToCycles(input int ns);
    int cyc;
    cyc = (ns * CLOCK_KHZ + 999999) / 1000000;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[3:0];
  endfunction

  localparam logic [3:0] OC_DELAY0_CYC = hpcbNsToCycles(OC_DELAY0_NS);
  localparam logic [3:0] OC_DELAY1_CYC = hpcbNsToCycles(OC_DELAY1_NS);
  localparam logic [3:0] OC_DELAY2_CYC = hpcbNsToCycles(OC_DELAY2_NS);
  localparam logic [3:0] OC_DELAY3_CYC = hpcbNsToCycles(OC_DELAY3_NS);

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Two strap pins to a port mask over bits 3:1: none, port 1, ports 1-2, ports 1-3
  function automatic logic [7:0] hpcbStrapMask(input logic [1:0] code);
    case (code)
      2'h0: return 8'h00;
      2'h1: return 8'h02;
      2'h2: return 8'h06;
      default: return 8'h0E;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: src/hpcb_oc_if.sv */
// Interface between the config bank and one over-current filter
`default_nettype none
interface hpcb_oc_if;
  logic [3:0] delayCycles;
  logic       senseIn;
  logic       tripped;

  modport owner (output delayCycles, output senseIn, input tripped);
  modport filter (input delayCycles, input senseIn, output tripped);
endinterface
`default_nettype wire

/* File: src/hpcb_oc_filter.sv */
// Over-current filter: trips once sense has held for the selected number of cycles
`default_nettype none
module hpcb_oc_filter
  import hpcb_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   reset,
  hpcb_oc_if.filter   oc
);

  logic [3:0] count_reg;
  logic       trip_reg;

  // Glitches shorter than the delay never reach the trip flag
  always_ff @(posedge clock) begin
    if (reset || !oc.senseIn) begin
      count_reg <= 4'h0;
      trip_reg <= 1'b0;
    end else if (count_reg + 4'h1 >= oc.delayCycles) begin
      trip_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + 4'h1;
    end
  end

  assign oc.tripped = trip_reg;

endmodule
`default_nettype wire

/* File: bench/hpcb_config_bank_chk.sv */
// Checker: port-level properties of the hub port config bank
`default_nettype none
module hpcb_config_bank_chk
  import hpcb_pkg::*;
#(
  parameter int PORTS = 3
) (
  input wire logic               clock,
  input wire logic               reset,
  input wire logic               s_axi_rvalid,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               internalDefaultStrap,
  input wire logic [1:0]         fixed_attach_straps,
  input wire logic [PORTS-1:0]   overcurrentSense,
  input wire logic               hubCompound,
  input wire logic [PORTS-1:0]   fixedAttachPorts,
  input wire logic [PORTS-1:0]   portEnabled,
  input wire logic [2*PORTS-1:0] logicalPortNum,
  input wire logic [1:0]         reportedPortCount,
  input wire logic [1:0]         overcurrent_delay_sel,
  input wire logic               explicit_port_remap_sel,
  input wire logic [PORTS-1:0]   overcurrentTripped
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] senseRun_reg;
  logic [4:0] need;

  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);

  // Held cycles of sense on port 1; saturates so a long hold cannot wrap
  always_ff @(posedge clock) begin
    if (reset || !overcurrentSense[0]) begin
      senseRun_reg <= 5'h00;
    end else if (senseRun_reg != 5'h1F) begin
      senseRun_reg <= senseRun_reg + 5'h01;
    end
  end
  assign need = 5'h01 << overcurrent_delay_sel;

  // Straps steady long enough to cross the synchronisers
  sequence strapSteady;
    ($stable(internalDefaultStrap) && $stable(fixed_attach_straps)) [*8];
  endsequence
  sequence stdSteady;
    !explicit_port_remap_sel [*4];
  endsequence

  rd_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  strap_compound_a: assert property (
    strapSteady ##0 (internalDefaultStrap && fixed_attach_straps != 2'h0) |-> hubCompound)
    else $error("strap fixed port without compound");
  port_count_a: assert property (reportedPortCount == $countones(portEnabled))
    else $error("port count differs from enabled ports");
  fixed_enabled_a: assert property ((fixedAttachPorts & ~portEnabled) == '0)
    else $error("fixed flag on a port not offered");
  number_enable_a: assert property ((logicalPortNum[1:0] != 2'h0) == portEnabled[0] &&
    (logicalPortNum[3:2] != 2'h0) == portEnabled[1] && (logicalPortNum[5:4] != 2'h0) == portEnabled[2])
    else $error("port number and enable disagree");
  std_first_a: assert property (stdSteady ##0 portEnabled[0] |-> logicalPortNum[1:0] == 2'h1)
    else $error("first port not numbered one");
  std_last_a: assert property (
    stdSteady ##0 portEnabled[2] |-> logicalPortNum[5:4] == reportedPortCount)
    else $error("last port number not contiguous");
  trip_min_a: assert property ($rose(overcurrentTripped[0]) |-> senseRun_reg >= need)
    else $error("over-current tripped before delay");
  trip_max_a: assert property (senseRun_reg == need + 5'h0A |-> overcurrentTripped[0])
    else $error("over-current not tripped after delay");
endmodule
`default_nettype wire

/* File: bench/hpcb_fw_model.sv */
// Firmware model: AXI4-Lite master that writes and reads the hub configuration bytes
`default_nettype none
module hpcb_fw_model (
  input  wire logic        clock,
  output var  logic [15:0] s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [15:0] s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Register traffic only; a fixed device brings its own descriptors
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'h0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // Ready sampled mid-cycle; released payload inverted
    while (!tb) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clock);
      if (ta) begin
        s_axi_awvalid <= 1'h0;
        s_axi_awaddr <= ~a;
      end
      if (tw) begin
        s_axi_wvalid <= 1'h0;
        s_axi_wdata <= ~s_axi_wdata;
      end
      if (tb) begin
        s_axi_bready <= 1'h0;
      end
    end
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'h0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tr) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) begin
        s_axi_arvalid <= 1'h0;
        s_axi_araddr <= ~a;
      end
      if (tr) begin
        s_axi_rready <= 1'h0;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_hub_port_config_bytes.sv */
// Testbench: config bank against a behavioural register and numbering model
`default_nettype none
module tb_hub_port_config_bytes
  import hpcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock, reset, internalDefaultStrap, hubCompound, explicit_port_remap_sel, power_source_sel;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fixed_attach_straps, portDisableStraps;
  logic [1:0]  reportedPortCount, overcurrent_delay_sel;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  overcurrentSense, fixedAttachPorts, portEnabled, overcurrentTripped;
  logic [5:0]  logicalPortNum;
  int          err_count, num_checks, seed;
  logic [7:0]  regs [int];
  int          mapped [7] = '{IDX_POWER_CONFIG, IDX_CONFIG_BYTE_TWO, IDX_CONFIG_BYTE_THREE,
                              IDX_FIXED_PORT_FLAGS, IDX_PORT_OFF_SELF_POWERED, IDX_PORT_OFF_BUS_POWERED,
                              IDX_PORT_REMAP_ONE_TWO};
  logic [15:0] maps [3] = '{16'h1302, 16'h0201, 16'h3100};

  hpcb_config_bank #(.PORTS(3)) dut (.*);
  hpcb_fw_model fw (.*);

  always #25 clock = ~clock;

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Writable bits per register; the rest are reserved
  function automatic logic [7:0] wmask(int idx);
    case (idx)
      IDX_POWER_CONFIG: return MASK_POWER_CONFIG;
      IDX_CONFIG_BYTE_TWO: return MASK_CONFIG_BYTE_TWO;
      IDX_CONFIG_BYTE_THREE: return MASK_CONFIG_BYTE_THREE;
      IDX_PORT_REMAP_ONE_TWO, IDX_PORT_REMAP_THREE: return MASK_PORT_REMAP;
      default: return MASK_PORT_FLAGS;
    endcase
  endfunction

  task automatic put(int idx, logic [7:0] d);
    logic [1:0] r;
    fw.wr(16'(idx * 4), d, r);
    chk(r, regs.exists(idx) ? RESP_OKAY : RESP_SLVERR);
    if (regs.exists(idx)) regs[idx] = d & wmask(idx);
  endtask

  task automatic get(int idx);
    logic [31:0] d;
    logic [1:0]  r;
    fw.rd(16'(idx * 4), d, r);
    chk(r, regs.exists(idx) ? RESP_OKAY : RESP_SLVERR);
    chk(d, regs.exists(idx) ? {24'h000000, regs[idx]} : 32'h00000000);
  endtask

  // Expected hub outputs once settled
  task automatic cmpOut();
    logic [2:0] en, dis, fx;
    logic [5:0] num;
    logic [1:0] cnt;
    repeat (8) @(posedge clock);
    @(negedge clock);
    cnt = 2'h0;
    num = 6'h00;
    dis = internalDefaultStrap ? 3'((1 << portDisableStraps) - 1) : (regs[IDX_POWER_CONFIG][7] ?
          regs[IDX_PORT_OFF_SELF_POWERED][3:1] : regs[IDX_PORT_OFF_BUS_POWERED][3:1]);
    for (int i = 0; i < 3; i++) begin
      if (regs[IDX_CONFIG_BYTE_THREE][3]) begin
        num[2*i+:2] = i == 2 ? regs[IDX_PORT_REMAP_THREE][1:0] : regs[IDX_PORT_REMAP_ONE_TWO][4*i+:2];
      end else if (!dis[i]) begin
        num[2*i+:2] = cnt + 2'h1;
      end
      en[i] = num[2*i+:2] != 2'h0;
      cnt = cnt + 2'(en[i]);
    end
    fx = (internalDefaultStrap ? 3'((1 << fixed_attach_straps) - 1) : regs[IDX_FIXED_PORT_FLAGS][3:1]) & en;
    chk(portEnabled, en);
    chk(logicalPortNum, num);
    chk(reportedPortCount, cnt);
    chk(fixedAttachPorts, fx);
    chk(hubCompound, internalDefaultStrap ? fixed_attach_straps != 2'h0 : regs[IDX_CONFIG_BYTE_TWO][3]);
    chk({overcurrent_delay_sel, explicit_port_remap_sel, power_source_sel}, {regs[IDX_CONFIG_BYTE_TWO][5:4],
        regs[IDX_CONFIG_BYTE_THREE][3], regs[IDX_POWER_CONFIG][7]});
  endtask

  // Sense all ports for len cycles; trip only from the delay on
  task automatic pulse(int len, int c);
    logic [2:0] seen;
    seen = 3'h0;
    for (int i = 0; i < len + 14; i++) begin
      @(posedge clock);
      overcurrentSense <= i < len ? 3'h7 : 3'h0;
      @(negedge clock);
      seen = seen | overcurrentTripped;
    end
    chk(seen, len >= (1 << c) ? 3'h7 : 3'h0);
    chk(overcurrentTripped, 3'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {clock, reset, internalDefaultStrap, fixed_attach_straps, portDisableStraps} = 7'h20;
    overcurrentSense = 3'h0;
    seed = $urandom(32'h93FA);
    foreach (mapped[i]) regs[mapped[i]] = 8'h00;
    regs[IDX_PORT_REMAP_THREE] = 8'h00;
    repeat (10) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    // Reset values and the unmapped place
    foreach (regs[i]) get(i);
    get(14'h0010);
    put(14'h0010, 8'hFF);
    cmpOut();
    $display("test reset done");
    // Random bytes, reserved bits too; remap off
    repeat (3) begin
      foreach (regs[i]) put(i, i == IDX_CONFIG_BYTE_THREE ? 8'($urandom) & 8'hF7 : 8'($urandom));
      foreach (regs[i]) get(i);
      cmpOut();
    end
    $display("test random done");
    // Each disable pattern under both power sources
    for (int p = 0; p < 16; p++) begin
      put(IDX_POWER_CONFIG, {p[3], 7'h00});
      put(IDX_PORT_OFF_SELF_POWERED, {4'h0, p[2:0], 1'h0});
      put(IDX_PORT_OFF_BUS_POWERED, {4'h0, ~p[2:0], 1'h0});
      cmpOut();
    end
    put(IDX_PORT_OFF_SELF_POWERED, 8'h00);
    put(IDX_PORT_OFF_BUS_POWERED, 8'h00);
    put(IDX_CONFIG_BYTE_THREE, 8'h08);
    foreach (maps[i]) begin
      put(IDX_PORT_REMAP_ONE_TWO, maps[i][15:8]);
      put(IDX_PORT_REMAP_THREE, maps[i][7:0]);
      cmpOut();
    end
    put(IDX_CONFIG_BYTE_THREE, 8'h00);
    $display("test numbering done");
    // Firmware compound with reader port fixed, then straps
    put(IDX_FIXED_PORT_FLAGS, 8'h02);
    put(IDX_CONFIG_BYTE_TWO, 8'h08);
    cmpOut();
    put(IDX_CONFIG_BYTE_TWO, 8'h00);
    for (int s = 0; s < 16; s++) begin
      @(posedge clock);
      internalDefaultStrap <= 1'h1;
      fixed_attach_straps <= 2'(s);
      portDisableStraps <= 2'(s >> 2);
      cmpOut();
    end
    @(posedge clock);
    internalDefaultStrap <= 1'h0;
    $display("test straps done");
    for (int c = 0; c < 4; c++) begin
      put(IDX_CONFIG_BYTE_TWO, 8'(c << 4));
      pulse((1 << c) - 1, c);
      pulse(20, c);
    end
    $display("test overcurrent done");
    tally_and_finish();
  end
endmodule

bind hpcb_config_bank hpcb_config_bank_chk #(.PORTS(PORTS)) chk (.*);
`default_nettype wire
